/* rtl/tsa_pkg.sv */
// Purpose: Shared constants and types of the temperature alarm block
// Assumes: 250 MHz core clock, 24-clock serial frames
// Notes:   Limit registers keep bits 15..7, temperature bits 15..3
package tsa_pkg;
    localparam int          CLK_MHZ     = 250;
    localparam int          CONV_MS     = 500;
    localparam int          CONV_CYCLES = CONV_MS * 1000 * CLK_MHZ;
    localparam logic [4:0]  FRAME_CLKS  = 5'h18;
    localparam logic [4:0]  CMD_CLKS    = 5'h08;
    localparam logic [4:0]  CNT_OVER    = 5'h19;
    localparam logic [1:0]  QUEUE_LAST  = 2'h3;
    // Command codes
    localparam logic [7:0]  CMD_RD_TEMP = 8'hc1;
    localparam logic [7:0]  CMD_RD_CFG  = 8'hc3;
    localparam logic [7:0]  CMD_RD_HYST = 8'hc5;
    localparam logic [7:0]  CMD_RD_CRIT = 8'hc7;
    localparam logic [7:0]  CMD_RD_LOW  = 8'hc9;
    localparam logic [7:0]  CMD_RD_UP   = 8'hcb;
    localparam logic [7:0]  CMD_WR_CFG  = 8'h83;
    localparam logic [7:0]  CMD_WR_HYST = 8'h85;
    localparam logic [7:0]  CMD_WR_CRIT = 8'h87;
    localparam logic [7:0]  CMD_WR_LOW  = 8'h89;
    localparam logic [7:0]  CMD_WR_UP   = 8'h8b;
    localparam int          CMD_START   = 7;
    localparam int          CMD_READ    = 6;
    // sensor_config fields
    localparam int          CFG_QUEUE   = 12;
    localparam int          CFG_FPOL    = 11;
    localparam int          CFG_OPOL    = 10;
    localparam int          CFG_IRQ     = 9;
    localparam int          CFG_SHDN    = 8;
    localparam logic [15:0] CFG_WMASK   = 16'h1f00;
    localparam logic [15:0] LIM_WMASK   = 16'hff80;
    // Temperature flag positions
    localparam int          FLG_CRIT    = 2;
    localparam int          FLG_UP      = 1;
    localparam int          FLG_LOW     = 0;
    // Reset values
    localparam logic [15:0] RST_CFG     = 16'h0000;
    localparam logic [15:0] RST_TEMP    = 16'h0000;
    localparam logic [15:0] RST_HYST    = 16'h0100;
    localparam logic [15:0] RST_CRIT    = 16'h2800;
    localparam logic [15:0] RST_LOW     = 16'h0500;
    localparam logic [15:0] RST_UP      = 16'h2000;

    typedef enum logic [1:0] {AL_IDLE, AL_TRIP, AL_CLR, AL_BACK} tsa_al_t;

    typedef struct packed {
        logic [4:0]  cnt;
        logic [23:0] sh;
    } tsa_lnk_t;

    typedef struct packed {
        logic        oe;
        logic [15:0] sh;
    } tsa_tx_t;

    typedef struct packed {
        logic        sel_s1;
        logic        sel_s2;
        logic        sel_d;
        logic [12:0] adc_s1;
        logic [12:0] adc_s2;
        logic [31:0] timer;
        logic [15:0] cfg;
        logic [15:0] hyst;
        logic [15:0] crit;
        logic [15:0] low;
        logic [15:0] up;
        logic [15:0] temp;
        logic [15:0] hold;
        tsa_al_t     al_st;
        logic        al_hi;
        logic [1:0]  al_q;
        logic        ot;
        logic [1:0]  ot_q;
    } tsa_core_t;
endpackage

/* rtl/tsa_top.sv */
// Purpose: Serial register port, conversion pacing and alarm outputs
// Assumes: i_sclk only toggles inside frames; frame words quasi-static
// Notes:   Core samples link words only after select_n rise is synced
`timescale 1ns/1ps

module tsa_top #(
    parameter int P_CONV_CYCLES = tsa_pkg::CONV_CYCLES
) (
    input  wire logic        i_clk,       // Core clock, 250 MHz
    input  wire logic        i_arst_n,    // Async reset, active low
    input  wire logic        i_sclk,      // Shift clock from master
    input  wire logic        i_select_n,  // Frame select, active low
    input  wire logic        i_sio_i,     // Data line level
    output logic             o_sio_o,     // Data line drive value
    output logic             o_sio_oe,    // Data line drive enable
    input  wire logic [12:0] i_adc_code,  // Converter sign and data
    output logic             o_fault_o,   // Fault pin value, always 0
    output logic             o_fault_oe,  // Fault pin pulls low
    output logic             o_overheat_o,  // Overheat pin value, 0
    output logic             o_overheat_oe  // Overheat pin pulls low
);
    tsa_pkg::tsa_lnk_t  lnk_reg;
    tsa_pkg::tsa_lnk_t  lnk_next;
    tsa_pkg::tsa_tx_t   tx_reg;
    tsa_pkg::tsa_tx_t   tx_next;
    tsa_pkg::tsa_core_t st_reg;
    tsa_pkg::tsa_core_t st_next;
    logic               idle_reg;
    logic               sel_rise;
    logic               frame_ok;
    logic [7:0]         f_cmd;
    logic [15:0]        f_data;
    logic               wr_ok;
    logic               rd_temp;
    logic               irq;
    logic               qen;
    logic               tick;
    logic signed [16:0] tv;
    logic signed [16:0] up_v;
    logic signed [16:0] lo_v;
    logic signed [16:0] cr_v;
    logic signed [16:0] hy_v;
    logic               c_hi;
    logic               c_lo;
    logic               c_cr;
    logic               r_up;
    logic               r_lo;
    logic               r_cr;
    logic               al_on;

    function automatic logic [16:0] sx(input logic [15:0] v);
        sx = {v[15], v};
    endfunction

    function automatic logic [1:0] q_inc(input logic c,
                                         input logic [1:0] q);
        if (!c) begin
            q_inc = 2'h0;
        end else if (q == tsa_pkg::QUEUE_LAST) begin
            q_inc = q;
        end else begin
            q_inc = q + 2'h1;
        end
    endfunction

    function automatic logic fires(input logic c, input logic [1:0] q,
                                   input logic en);
        fires = c && (!en || q == tsa_pkg::QUEUE_LAST);
    endfunction

    // ---------------- Link side, shift clock domain ----------------

    // Idle flag stands for the cleared bit counter while select is high
    always_ff @(posedge i_sclk or posedge i_select_n
                or negedge i_arst_n) begin
        if (!i_arst_n || i_select_n) begin
            idle_reg <= 1'b1;
        end else begin
            idle_reg <= 1'b0;
        end
    end

    always_comb begin
        lnk_next = lnk_reg;
        if (!i_select_n) begin
            // Saturate so that overlong frames stay distinguishable
            if (idle_reg) begin
                lnk_next.cnt = 5'h01;
            end else if (lnk_reg.cnt != tsa_pkg::CNT_OVER) begin
                lnk_next.cnt = lnk_reg.cnt + 5'h01;
            end
            lnk_next.sh = {lnk_reg.sh[22:0], i_sio_i};
        end
    end

    always_ff @(posedge i_sclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            lnk_reg <= '0;
        end else begin
            lnk_reg <= lnk_next;
        end
    end

    // Hold, config and limit registers are frozen while a frame runs, so sampling is safe
    always_comb begin
        logic [7:0] cmd;
        cmd = lnk_reg.sh[7:0];
        tx_next = tx_reg;
        if (!idle_reg && lnk_reg.cnt == tsa_pkg::CMD_CLKS) begin
            tx_next.oe = cmd[tsa_pkg::CMD_START]
                         && cmd[tsa_pkg::CMD_READ];
            case (cmd)
                tsa_pkg::CMD_RD_TEMP: tx_next.sh = st_reg.hold;
                tsa_pkg::CMD_RD_CFG:  tx_next.sh = st_reg.cfg;
                tsa_pkg::CMD_RD_HYST: tx_next.sh = st_reg.hyst;
                tsa_pkg::CMD_RD_CRIT: tx_next.sh = st_reg.crit;
                tsa_pkg::CMD_RD_LOW:  tx_next.sh = st_reg.low;
                tsa_pkg::CMD_RD_UP:   tx_next.sh = st_reg.up;
                default:              tx_next.sh = 16'h0000;
            endcase
        end else if (tx_reg.oe) begin
            tx_next.sh = {tx_reg.sh[14:0], 1'b0};
        end
    end

    // Release of the line is immediate on select rise
    always_ff @(negedge i_sclk or negedge i_arst_n
                or posedge i_select_n) begin
        if (!i_arst_n || i_select_n) begin
            tx_reg <= '0;
        end else begin
            tx_reg <= tx_next;
        end
    end

    assign o_sio_o  = tx_reg.sh[15];
    assign o_sio_oe = tx_reg.oe;

    // ---------------- Core side, i_clk domain ----------------

    assign sel_rise = st_reg.sel_s2 && !st_reg.sel_d;
    assign f_cmd    = lnk_reg.sh[23:16];
    assign f_data   = lnk_reg.sh[15:0];
    assign frame_ok = sel_rise
                      && lnk_reg.cnt == tsa_pkg::FRAME_CLKS;
    assign wr_ok    = frame_ok && !f_cmd[tsa_pkg::CMD_READ];
    assign rd_temp  = frame_ok && f_cmd == tsa_pkg::CMD_RD_TEMP;
    assign irq      = st_reg.cfg[tsa_pkg::CFG_IRQ];
    assign qen      = st_reg.cfg[tsa_pkg::CFG_QUEUE];
    assign tick     = !st_reg.cfg[tsa_pkg::CFG_SHDN]
                      && st_reg.timer
                         == 32'(P_CONV_CYCLES - 1);

    assign tv   = {st_reg.adc_s2[12], st_reg.adc_s2, 3'b000};
    assign up_v = sx(st_reg.up);
    assign lo_v = sx(st_reg.low);
    assign cr_v = sx(st_reg.crit);
    assign hy_v = sx(st_reg.hyst);
    assign c_hi = tv > up_v;
    assign c_lo = tv < lo_v;
    assign c_cr = tv > cr_v;
    assign r_up = tv < 17'(up_v - hy_v);
    assign r_lo = tv > 17'(lo_v + hy_v);
    assign r_cr = tv < 17'(cr_v - hy_v);

    always_comb begin
        logic cond;
        cond = 1'b0;
        st_next = st_reg;
        st_next.sel_s1 = i_select_n;
        st_next.sel_s2 = st_reg.sel_s1;
        st_next.sel_d  = st_reg.sel_s2;
        st_next.adc_s1 = i_adc_code;
        st_next.adc_s2 = st_reg.adc_s1;
        if (st_reg.sel_s2) begin
            st_next.hold = st_reg.temp;
        end
        if (sel_rise) begin
            st_next.timer = 32'h0;
        end else if (tick) begin
            st_next.timer = 32'h0;
        end else if (!st_reg.cfg[tsa_pkg::CFG_SHDN]) begin
            st_next.timer = st_reg.timer + 32'h1;
        end
        if (wr_ok) begin
            case (f_cmd)
                tsa_pkg::CMD_WR_CFG:
                    st_next.cfg = f_data & tsa_pkg::CFG_WMASK;
                tsa_pkg::CMD_WR_HYST:
                    st_next.hyst = f_data & tsa_pkg::LIM_WMASK;
                tsa_pkg::CMD_WR_CRIT:
                    st_next.crit = f_data & tsa_pkg::LIM_WMASK;
                tsa_pkg::CMD_WR_LOW:
                    st_next.low = f_data & tsa_pkg::LIM_WMASK;
                tsa_pkg::CMD_WR_UP:
                    st_next.up = f_data & tsa_pkg::LIM_WMASK;
                default: ;
            endcase
        end
        // Read clear first, so a fault found this cycle still wins
        if (rd_temp && irq) begin
            case (st_reg.al_st)
                tsa_pkg::AL_TRIP: begin
                    st_next.al_st = tsa_pkg::AL_CLR;
                    st_next.al_q  = 2'h0;
                end
                tsa_pkg::AL_BACK: begin
                    st_next.al_st = tsa_pkg::AL_IDLE;
                    st_next.al_q  = 2'h0;
                end
                default: ;
            endcase
        end
        if (!irq && st_next.al_st != tsa_pkg::AL_TRIP) begin
            st_next.al_st = tsa_pkg::AL_IDLE;
        end
        if (tick) begin
            st_next.temp = {st_reg.adc_s2, c_cr, c_hi, c_lo};
            case (st_next.al_st)
                tsa_pkg::AL_IDLE: begin
                    cond = c_hi || c_lo;
                    if (fires(cond, st_next.al_q, qen)) begin
                        st_next.al_st = tsa_pkg::AL_TRIP;
                        st_next.al_hi = c_hi;
                        st_next.al_q  = 2'h0;
                    end else begin
                        st_next.al_q = q_inc(cond, st_next.al_q);
                    end
                end
                tsa_pkg::AL_TRIP: begin
                    // Latched in interrupt mode until read
                    if (!irq && (st_reg.al_hi ? r_up : r_lo)) begin
                        st_next.al_st = tsa_pkg::AL_IDLE;
                    end
                end
                tsa_pkg::AL_CLR: begin
                    cond = st_reg.al_hi ? r_up : r_lo;
                    if (fires(cond, st_next.al_q, qen)) begin
                        st_next.al_st = tsa_pkg::AL_BACK;
                        st_next.al_q  = 2'h0;
                    end else begin
                        st_next.al_q = q_inc(cond, st_next.al_q);
                    end
                end
                tsa_pkg::AL_BACK: ;
                default: st_next.al_st = tsa_pkg::AL_IDLE;
            endcase
            if (!st_reg.ot) begin
                if (fires(c_cr, st_reg.ot_q, qen)) begin
                    st_next.ot   = 1'b1;
                    st_next.ot_q = 2'h0;
                end else begin
                    st_next.ot_q = q_inc(c_cr, st_reg.ot_q);
                end
            end else if (r_cr) begin
                st_next.ot = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_reg       <= '0;
            st_reg.sel_s1 <= 1'b1;
            st_reg.sel_s2 <= 1'b1;
            st_reg.sel_d  <= 1'b1;
            st_reg.cfg   <= tsa_pkg::RST_CFG;
            st_reg.hyst  <= tsa_pkg::RST_HYST;
            st_reg.crit  <= tsa_pkg::RST_CRIT;
            st_reg.low   <= tsa_pkg::RST_LOW;
            st_reg.up    <= tsa_pkg::RST_UP;
            st_reg.temp  <= tsa_pkg::RST_TEMP;
            st_reg.hold  <= tsa_pkg::RST_TEMP;
            st_reg.al_st <= tsa_pkg::AL_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign al_on = st_reg.al_st == tsa_pkg::AL_TRIP
                   || st_reg.al_st == tsa_pkg::AL_BACK;
    // Open drain: pull low when the active level is low
    assign o_fault_o     = 1'b0;
    assign o_fault_oe    = al_on ^ st_reg.cfg[tsa_pkg::CFG_FPOL];
    assign o_overheat_o  = 1'b0;
    assign o_overheat_oe = st_reg.ot
                           ^ st_reg.cfg[tsa_pkg::CFG_OPOL];

    // ---------------- Checks ----------------

    a_cfg_reserved: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        (st_reg.cfg & ~tsa_pkg::CFG_WMASK) == 16'h0000)
        else $error("reserved config bit set");

    a_cfg_commit: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        !$stable(st_reg.cfg) |-> $past(sel_rise)
            && $past(lnk_reg.cnt) == tsa_pkg::FRAME_CLKS
            && $past(f_cmd) == tsa_pkg::CMD_WR_CFG)
        else $error("config changed without valid frame");

    a_shdn_freeze: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        st_reg.cfg[tsa_pkg::CFG_SHDN] |=> $stable(st_reg.temp))
        else $error("temperature changed in shutdown");

    a_cmp_no_clear: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        !irq && al_on && rd_temp && !tick |=> al_on)
        else $error("comparator fault cleared by read");

    a_irq_read_clear: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        irq && st_reg.al_st == tsa_pkg::AL_TRIP && rd_temp && !tick
        && !wr_ok |=> !al_on)
        else $error("latched fault not cleared by read");

    a_queue_four: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        $past(qen) && $rose(st_reg.ot) |-> $past(st_reg.ot_q)
            == tsa_pkg::QUEUE_LAST && $past(c_cr))
        else $error("overheat before four faulty conversions");

    a_ot_release: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        $fell(st_reg.ot) |-> $past(tick) && $past(r_cr))
        else $error("overheat released above hysteresis point");

    a_ot_polarity: assert property (
        @(posedge i_clk) disable iff (!i_arst_n)
        o_overheat_oe == (st_reg.ot != st_reg.cfg[tsa_pkg::CFG_OPOL]))
        else $error("overheat polarity wrong");

    sequence s_cmd_done;
        !idle_reg && lnk_reg.cnt == tsa_pkg::CMD_CLKS;
    endsequence

    a_drive_start: assert property (
        @(negedge i_sclk) disable iff (!i_arst_n || i_select_n)
        $rose(o_sio_oe) |-> $past(lnk_reg.cnt) == tsa_pkg::CMD_CLKS)
        else $error("data line driven at wrong clock");

    a_drive_read: assert property (
        @(negedge i_sclk) disable iff (!i_arst_n || i_select_n)
        s_cmd_done |=> o_sio_oe
            == $past(lnk_reg.sh[7] && lnk_reg.sh[6]))
        else $error("drive enable does not follow command");
endmodule

/* test/tsa_master.sv */
// Purpose: Serial master model that frames commands to the sensor
// Assumes: 32 ns shift clock that runs only inside frames
// Notes:   Undriven data line toggles, so a stale bit cannot pass
`timescale 1ns/1ps
module tsa_master (
    output logic      o_sclk,     // Shift clock
    output logic      o_select_n, // Frame select, active low
    output logic      o_sio,      // Resolved data line level
    input  wire logic i_dev_o,    // Device drive value
    input  wire logic i_dev_oe    // Device drive enable
);
    logic m_en;
    logic m_val;
    logic idle_v;
    initial begin
        o_sclk     = 1'b0;
        o_select_n = 1'b1;
        m_en       = 1'b0;
        m_val      = 1'b0;
        idle_v     = 1'b0;
    end
    always #3 idle_v = ~idle_v;
    assign o_sio = m_en ? m_val : (i_dev_oe ? i_dev_o : idle_v);

    // A frame with sel_off set toggles the clock with select held high
    task automatic frame(input logic [7:0] cmd, input logic [15:0] wd,
                         input int nclk, input logic sel_off,
                         output logic [15:0] rd, output logic ok);
        logic [23:0] word;
        logic        rdc;
        word = {cmd, wd};
        rdc  = cmd[6];
        rd   = 16'h0000;
        ok   = 1'b1;
        #1.5;
        o_select_n = sel_off;
        #84;
        for (int i = 0; i < nclk; i++) begin
            m_en  = (i < 8) || !rdc;
            m_val = (i < 24) ? word[23 - i] : 1'b0;
            #16;
            o_sclk = 1'b1;
            if (i >= 8) begin
                rd = {rd[14:0], o_sio};
                if (i_dev_oe !== (rdc && !sel_off)) ok = 1'b0;
            end else if (i_dev_oe !== 1'b0) begin
                ok = 1'b0;
            end
            #16;
            o_sclk = 1'b0;
        end
        #16;
        o_select_n = 1'b1;
        m_en       = 1'b0;
        #1;
        if (i_dev_oe !== 1'b0) ok = 1'b0;
        #40;
    endtask
endmodule

/* test/tsa_top_tb.sv */
// Purpose: Register, conversion and alarm checks of the sensor block
// Assumes: Short conversion period; alarm pins pulled up
// Notes:   Expected words are worked out from limits and codes
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tsa_top_tb;
    localparam int NCONV = 40;
    logic        i_clk;
    logic        i_arst_n;
    logic        sclk;
    logic        select_n;
    logic        serial_line_bidir;
    logic        sio_o;
    logic        sio_oe;
    logic [12:0] adc;
    logic        fault_oe;
    logic        fault_o;
    logic        ot_o;
    logic        ot_oe;
    int          fail_count;
    int          compares;
    int          cycles;
    logic [7:0]  rc [6];
    logic [7:0]  wc [6];
    logic [15:0] rv [6];
    logic [12:0] st_adc [10];
    logic [1:0]  st_al [10];

    tsa_top #(.P_CONV_CYCLES(NCONV)) u_tsa_top (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_sclk(sclk),
        .i_select_n(select_n), .i_sio_i(serial_line_bidir), .o_sio_o(sio_o),
        .o_sio_oe(sio_oe), .i_adc_code(adc), .o_fault_o(fault_o),
        .o_fault_oe(fault_oe), .o_overheat_o(ot_o), .o_overheat_oe(ot_oe));
    tsa_master u_tsa_master (
        .o_sclk(sclk), .o_select_n(select_n), .o_sio(serial_line_bidir),
        .i_dev_o(sio_o), .i_dev_oe(sio_oe));

    initial i_clk = 1'b0;
    always #2 i_clk = ~i_clk;

    task automatic finish_test();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            finish_test();
        end
    end

    task automatic xfer(input logic [7:0] c, input logic [15:0] d,
                        input int n, input logic off,
                        output logic [15:0] r);
        logic ok;
        @(negedge i_clk);
        u_tsa_master.frame(c, d, n, off, r, ok);
        `CHK(ok, 1'b1)
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        logic [15:0] r;
        xfer(c, d, 24, 1'b0, r);
    endtask
    task automatic rd_chk(input logic [7:0] c, input logic [15:0] e);
        logic [15:0] r;
        xfer(c, 16'h0000, 24, 1'b0, r);
        `CHK(r, e)
    endtask
    task automatic al_chk(input logic f, input logic o);
        `CHK(fault_oe, f)
        `CHK(ot_oe, o)
        `CHK(fault_o | ot_o, 1'b0)
    endtask
    task automatic conv(input logic [12:0] a, input int n);
        @(negedge i_clk);
        adc = a;
        repeat (n * NCONV + 10) @(negedge i_clk);
    endtask

    initial begin
        logic [15:0] r;
        rc = '{tsa_pkg::CMD_RD_TEMP, tsa_pkg::CMD_RD_CFG,
               tsa_pkg::CMD_RD_HYST, tsa_pkg::CMD_RD_CRIT,
               tsa_pkg::CMD_RD_LOW, tsa_pkg::CMD_RD_UP};
        wc = '{8'h00, tsa_pkg::CMD_WR_CFG, tsa_pkg::CMD_WR_HYST,
               tsa_pkg::CMD_WR_CRIT, tsa_pkg::CMD_WR_LOW,
               tsa_pkg::CMD_WR_UP};
        rv = '{16'h0000, 16'h0000, 16'h0100, 16'h2800, 16'h0500,
               16'h2000};
        st_adc = '{13'h0460, 13'h03f0, 13'h03d0, 13'h0090, 13'h00b0,
                   13'h00d0, 13'h0510, 13'h04f0, 13'h04d0, 13'h0190};
        st_al = '{2'h2, 2'h2, 2'h0, 2'h2, 2'h2, 2'h0, 2'h3, 2'h3, 2'h2,
                  2'h0};
        fail_count = 0;
        compares   = 0;
        cycles     = 0;
        i_arst_n   = 1'b0;
        adc        = 13'h0190;
        repeat (12) @(negedge i_clk);
        i_arst_n = 1'b1;
        repeat (4) @(negedge i_clk);
        al_chk(1'b0, 1'b0);
        for (int i = 0; i < 6; i++) rd_chk(rc[i], rv[i]);
        rd_chk(8'hcd, 16'h0000);
        wr(8'h8d, 16'h1f00);
        wr(wc[1], 16'hffff);
        rd_chk(rc[1], 16'h1f00);
        al_chk(1'b1, 1'b1);
        wr(wc[1], 16'h0000);
        xfer(wc[1], 16'h0200, 8, 1'b1, r);
        xfer(wc[1], 16'h0200, 23, 1'b0, r);
        xfer(wc[1], 16'h0200, 25, 1'b0, r);
        rd_chk(rc[1], 16'h0000);
        for (int i = 2; i < 6; i++) begin
            wr(wc[i], rv[i] | 16'h007f);
            rd_chk(rc[i], rv[i]);
        end
        conv(13'h0190, 1);
        rd_chk(rc[0], 16'h0c80);
        for (int i = 0; i < 10; i++) begin
            conv(st_adc[i], 1);
            al_chk(st_al[i][1], st_al[i][0]);
        end
        conv(13'h0460, 1);
        rd_chk(rc[0], 16'h2302);
        al_chk(1'b1, 1'b0);
        conv(13'h0190, 1);
        wr(wc[1], 16'h0c00);
        al_chk(1'b1, 1'b1);
        conv(13'h0460, 1);
        al_chk(1'b0, 1'b1);
        wr(wc[1], 16'h0200);
        conv(13'h0190, 1);
        al_chk(1'b1, 1'b0);
        wr(wc[1], 16'h0000);
        conv(13'h0190, 1);
        al_chk(1'b0, 1'b0);
        wr(wc[1], 16'h0200);
        conv(13'h0460, 1);
        al_chk(1'b1, 1'b0);
        conv(13'h0190, 1);
        al_chk(1'b1, 1'b0);
        conv(13'h0460, 1);
        rd_chk(rc[0], 16'h2302);
        al_chk(1'b0, 1'b0);
        conv(13'h0460, 2);
        al_chk(1'b0, 1'b0);
        conv(13'h03d0, 1);
        al_chk(1'b1, 1'b0);
        wr(wc[1], 16'h0000);
        conv(13'h0190, 1);
        wr(wc[1], 16'h1000);
        conv(13'h0510, 3);
        al_chk(1'b0, 1'b0);
        repeat (NCONV) @(negedge i_clk);
        al_chk(1'b1, 1'b1);
        wr(wc[1], 16'h0000);
        conv(13'h0190, 1);
        wr(wc[1], 16'h0100);
        conv(13'h0460, 2);
        rd_chk(rc[0], 16'h0c80);
        rd_chk(rc[1], 16'h0100);
        al_chk(1'b0, 1'b0);
        finish_test();
    end
endmodule
